//--- core/faout_pkg.sv
// Package of constants and carrier types for the fault alarm output block
// Summary of operation
// - Assert alarm when fault trips the drive
// - Hold alarm until the fault is cleared
// - Option code 05 routes alarm to output
// - Relay default alarm, normally closed sense 01
// - Normally closed relay waits under 2 s
// - Open-collector output lags alarm by 300 ms
// - Open sense energizes on trip only
package faout_pkg;

   // Function option code that selects the alarm signal
   localparam logic [7:0] FAOUT_FUNC_ALARM   = 8'h05;
   // Relay polarity settings
   localparam logic [7:0] FAOUT_POL_NO       = 8'h00;
   localparam logic [7:0] FAOUT_POL_NC       = 8'h01;
   // Reset values of the settings
   localparam logic [7:0] FAOUT_RELAY_FN_RST = 8'h05;
   localparam logic [7:0] FAOUT_RELAY_PL_RST = 8'h01;
   localparam logic [7:0] FAOUT_OC_FN_RST    = 8'h00;

   // Clock rate and timing figures
   localparam longint FAOUT_CLK_HZ        = 200000000;
   localparam longint FAOUT_PWRUP_MS      = 1500;   // Below the 2 s ceiling
   localparam longint FAOUT_OC_DELAY_MS   = 300;
   localparam int     FAOUT_PWRUP_CYC     = int'(FAOUT_PWRUP_MS * FAOUT_CLK_HZ / 1000);
   localparam int     FAOUT_OC_DELAY_CYC  = int'(FAOUT_OC_DELAY_MS * FAOUT_CLK_HZ / 1000);
   localparam int     FAOUT_CNT_W         = 32;

   // Settings carried as one group
   typedef struct packed {
      logic [7:0] relay_function_select;  // Function of the relay
      logic [7:0] relay_polarity_select;  // Relay sense
      logic [7:0] oc_function_select;     // Function of the open-collector terminal
   } faout_cfg_type;

   // Power-up sequence states, Gray order
   typedef enum logic [1:0] {
      FAOUT_ST_WAIT = 2'b00,
      FAOUT_ST_RUN  = 2'b01
   } faout_state_type;

endpackage

//--- core/faout_delay.sv
// Delay line that follows its input once a new level has held for a fixed number of cycles
`timescale 1ns/100ps
module faout_delay
   import faout_pkg::*;
#(
   parameter int DELAY_CYC = 4
) (
   input  wire logic clk_i,   // Clock
   input  wire logic rst_i,   // Synchronous reset, high
   input  wire logic d_i,     // Level to follow
   output logic      q_o      // Delayed level
);

   logic [FAOUT_CNT_W-1:0] cnt_reg;  // Cycles the input has differed
   logic                   q_reg;    // Output level

   // Restart timing on every mismatch change; a glitch shorter than the delay is dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 32'h0;
         q_reg   <= 1'b0;
      end else if (d_i == q_reg) begin
         cnt_reg <= 32'h0;
      end else if (cnt_reg >= FAOUT_CNT_W'(DELAY_CYC - 1)) begin
         q_reg   <= d_i;
         cnt_reg <= 32'h0;
      end else begin
         cnt_reg <= cnt_reg + 32'h1;
      end
   end

   assign q_o = q_reg;

endmodule

//--- core/faout_top.sv
// Fault alarm output: latched alarm, relay drive and delayed open-collector drive
`timescale 1ns/100ps
module faout_top
   import faout_pkg::*;
#(
   parameter int PWRUP_CYC   = FAOUT_PWRUP_CYC,     // Power-up relay hold-off
   parameter int OC_DELAY_CYC = FAOUT_OC_DELAY_CYC  // Open-collector lag
) (
   input  wire logic          REF_CLK_I,          // 200 MHz clock
   input  wire logic          RST_I,              // Synchronous reset, high (power-up)
   input  wire logic          TRIP_I,             // Drive in trip state, same domain
   input  wire logic          CLEAR_I,            // Alarm clear pulse, same domain
   input  wire faout_cfg_type CFG_I,              // Settings
   output logic               FAULT_ALARM_SIGNAL_O, // Internal latched alarm
   output logic               RELAY_COIL_O,       // Relay energized
   output logic               OC_OUT_O            // Open-collector transistor on
);

   ////////////////////////////////////////////////////////////////////////
   // Alarm latch
   logic alarm_reg;  // Latched alarm
   logic alarm_next;

   // Trip wins over a clear in the same cycle so no fault is lost
   always_comb begin
      alarm_next = alarm_reg;
      if (CLEAR_I) begin
         alarm_next = 1'b0;
      end
      if (TRIP_I) begin
         alarm_next = 1'b1;
      end
   end

   // Store the alarm
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         alarm_reg <= 1'b0;
      end else begin
         alarm_reg <= alarm_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power-up hold-off
   faout_state_type        state_reg;  // Sequence state
   logic [FAOUT_CNT_W-1:0] pwr_cnt_reg; // Hold-off counter

   // Keep the relay off until the hold-off expires
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         state_reg   <= FAOUT_ST_WAIT;
         pwr_cnt_reg <= 32'h0;
      end else begin
         case (state_reg)
            FAOUT_ST_WAIT: begin
               if (pwr_cnt_reg >= FAOUT_CNT_W'(PWRUP_CYC - 1)) begin
                  state_reg <= FAOUT_ST_RUN;
               end else begin
                  pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
               end
            end
            default: begin
               state_reg <= FAOUT_ST_RUN;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Relay drive
   logic relay_reg;  // Coil drive
   logic relay_fn;   // Relay carries the alarm
   logic relay_nc;   // Normally-closed sense

   assign relay_fn = (CFG_I.relay_function_select == FAOUT_FUNC_ALARM);
   assign relay_nc = (CFG_I.relay_polarity_select == FAOUT_POL_NC);

   // Normally closed: coil on while healthy; open: coil on only on trip
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         relay_reg <= 1'b0;
      end else if (state_reg != FAOUT_ST_RUN || !relay_fn) begin
         relay_reg <= 1'b0;
      end else if (relay_nc) begin
         relay_reg <= !alarm_reg;
      end else begin
         relay_reg <= alarm_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Open-collector drive
   logic oc_alarm;  // Alarm gated by function select
   logic oc_q;      // Delayed level

   assign oc_alarm = alarm_reg && (CFG_I.oc_function_select == FAOUT_FUNC_ALARM);

   faout_delay #(
      .DELAY_CYC (OC_DELAY_CYC)
   ) u_oc_delay (
      .clk_i (REF_CLK_I),
      .rst_i (RST_I),
      .d_i   (oc_alarm),
      .q_o   (oc_q)
   );

   // Output flops
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         OC_OUT_O             <= 1'b0;
         FAULT_ALARM_SIGNAL_O <= 1'b0;
      end else begin
         OC_OUT_O             <= oc_q;
         FAULT_ALARM_SIGNAL_O <= alarm_reg;
      end
   end

   assign RELAY_COIL_O = relay_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_trip_sets;
      @(posedge REF_CLK_I) disable iff (RST_I)
      TRIP_I |=> ##1 FAULT_ALARM_SIGNAL_O;
   endproperty
   a_trip_sets: assert property (p_trip_sets) else $error("Trip did not raise alarm");

   property p_hold;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (alarm_reg && !CLEAR_I) |=> alarm_reg;
   endproperty
   a_hold: assert property (p_hold) else $error("Alarm dropped without clear");

   property p_clear;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (CLEAR_I && !TRIP_I) |=> !alarm_reg;
   endproperty
   a_clear: assert property (p_clear) else $error("Clear did not drop alarm");

   property p_oc_off;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (CFG_I.oc_function_select != FAOUT_FUNC_ALARM && !oc_q) |=> !oc_q;
   endproperty
   a_oc_off: assert property (p_oc_off) else $error("Open collector alarm while unselected");

   property p_nc_run;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (state_reg == FAOUT_ST_RUN && relay_fn && relay_nc && !alarm_reg) |=> relay_reg;
   endproperty
   a_nc_run: assert property (p_nc_run) else $error("Closed sense relay not energized");

   property p_pwrup;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (state_reg == FAOUT_ST_WAIT) |-> !relay_reg;
   endproperty
   a_pwrup: assert property (p_pwrup) else $error("Relay energized during hold-off");

   property p_oc_lag;
      @(posedge REF_CLK_I) disable iff (RST_I)
      ($rose(oc_alarm) && !oc_q) |=> !oc_q;
   endproperty
   a_oc_lag: assert property (p_oc_lag) else $error("Open collector changed without lag");

   property p_no_trip;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (relay_fn && !relay_nc && !alarm_reg) |=> !relay_reg;
   endproperty
   a_no_trip: assert property (p_no_trip) else $error("Open sense relay on without trip");

   property p_relay_unsel;
      @(posedge REF_CLK_I) disable iff (RST_I)
      !relay_fn |=> !relay_reg;
   endproperty
   a_relay_unsel: assert property (p_relay_unsel) else $error("Relay energized while unselected");

   property p_clear_out;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (CLEAR_I && !TRIP_I) |=> ##1 !FAULT_ALARM_SIGNAL_O;
   endproperty
   a_clear_out: assert property (p_clear_out) else $error("Clear did not drop alarm output");

   property p_nc_trip;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (relay_nc && alarm_reg) |=> !relay_reg;
   endproperty
   a_nc_trip: assert property (p_nc_trip) else $error("Closed sense relay held on a trip");

   property p_no_on;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (state_reg == FAOUT_ST_RUN && relay_fn && !relay_nc && alarm_reg) |=> relay_reg;
   endproperty
   a_no_on: assert property (p_no_on) else $error("Open sense relay not energized on trip");

   ////////////////////////////////////////////////////////////////////////
   // Check helpers: cycle counts kept apart from the logic they watch
   logic [FAOUT_CNT_W-1:0] chk_up_cnt_reg;   // Edges since reset release, saturating
   logic                   chk_oc_last_reg;  // Open-collector request one edge ago
   logic [FAOUT_CNT_W-1:0] chk_oc_cnt_reg;   // Edges since that request last changed

   // Count from release; saturation keeps the counter from wrapping in long runs
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         chk_up_cnt_reg <= 32'h0;
      end else if (chk_up_cnt_reg <= FAOUT_CNT_W'(PWRUP_CYC)) begin
         chk_up_cnt_reg <= chk_up_cnt_reg + 32'h1;
      end
   end

   // Time how long the open-collector request has been steady
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         chk_oc_last_reg <= 1'b0;
         chk_oc_cnt_reg  <= 32'h0;
      end else begin
         chk_oc_last_reg <= oc_alarm;
         if (oc_alarm != chk_oc_last_reg) begin
            chk_oc_cnt_reg <= 32'h1;  // Fresh change, restart the count
         end else if (chk_oc_cnt_reg <= FAOUT_CNT_W'(OC_DELAY_CYC)) begin
            chk_oc_cnt_reg <= chk_oc_cnt_reg + 32'h1;
         end
      end
   end

   property p_hold_min;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (chk_up_cnt_reg <= FAOUT_CNT_W'(PWRUP_CYC)) |-> !relay_reg;
   endproperty
   a_hold_min: assert property (p_hold_min) else $error("Relay energized before hold-off ended");

   property p_hold_max;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (chk_up_cnt_reg >= FAOUT_CNT_W'(PWRUP_CYC)) |-> (state_reg == FAOUT_ST_RUN);
   endproperty
   a_hold_max: assert property (p_hold_max) else $error("Hold-off lasted too long");

   // The reset edge itself clears the delay line, so it is not a lag event
   property p_oc_time;
      @(posedge REF_CLK_I) disable iff (RST_I)
      ($changed(oc_q) && !$past(RST_I)) |-> (chk_oc_cnt_reg == FAOUT_CNT_W'(OC_DELAY_CYC));
   endproperty
   a_oc_time: assert property (p_oc_time) else $error("Open collector lag length wrong");

endmodule

//--- dv/faout_alarm_loop.sv
// External alarm loop model wired across the relay common and contact a
`timescale 1ns/100ps
module faout_alarm_loop (
   input  wire logic coil_i,      // Relay coil energized
   output logic      loop_ok_o    // Loop closed, no alarm seen
);
   // Contact a closes only while the coil is energized, so a cut wire also reads as alarm
   assign loop_ok_o = coil_i;
endmodule

//--- dv/test_faout_top.sv
// Self-checking bench for the fault alarm output block
`timescale 1ns/100ps
module test_faout_top;
   import faout_pkg::*;
   logic          clk;          // 200 MHz clock
   logic          rst;          // Power-up reset
   logic          trip;         // Drive trip level
   logic          clr;          // Alarm clear
   faout_cfg_type cfg;          // Settings
   logic          alarm;        // Latched alarm
   logic          coil;         // Relay coil
   logic          oc;           // Open-collector drive
   logic          loop_ok;      // Far-side loop state
   logic [3:0]    exp_q[$];     // Expected {alarm, coil, oc, loop}
   event          smp_ev;       // Sample point
   int            miscompares;  // Mismatch count
   int            checks;       // Comparison count
   int            gap;          // Random wait
   //////////////////////////////////////////////////////////////////////
   // Short counts keep the run brief
   faout_top #(.PWRUP_CYC(10), .OC_DELAY_CYC(8)) uut (.REF_CLK_I(clk), .RST_I(rst), .TRIP_I(trip),
      .CLEAR_I(clr), .CFG_I(cfg), .FAULT_ALARM_SIGNAL_O(alarm), .RELAY_COIL_O(coil), .OC_OUT_O(oc));
   faout_alarm_loop far (.coil_i(coil), .loop_ok_o(loop_ok));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   //////////////////////////////////////////////////////////////////////
   // Step to just after the rising edge; drive and sample there
   task tick();
      @(posedge clk);
      #1;
   endtask
   // Note an expectation and wake the monitor
   task expect_out(input logic [2:0] v);
      exp_q.push_back({v, v[1]});
      -> smp_ev;
   endtask
   // Bounded wait for one output to reach a level
   task wait_bit(input int idx, input logic val);
      int         n;
      logic [2:0] outs;
      n = 0;
      outs = {alarm, coil, oc};
      while (outs[idx] !== val && n < 40) begin
         tick();
         n++;
         outs = {alarm, coil, oc};
      end
      if (outs[idx] !== val) begin
         miscompares++;
         end_sim();
      end
   endtask
   task end_sim();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Monitor takes the oldest note at each sample point
   always @(smp_ev) begin
      logic [3:0] got;
      got = {alarm, coil, oc, loop_ok};
      checks++;
      if (got !== exp_q[0]) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp_q[0]);
      end
      void'(exp_q.pop_front());
   end
   //////////////////////////////////////////////////////////////////////
   initial begin
      miscompares = 0;
      checks = 0;
      rst = 1'b1;
      trip = 1'b0;
      clr = 1'b0;
      cfg = '{FAOUT_FUNC_ALARM, FAOUT_POL_NC, FAOUT_FUNC_ALARM};
      void'($urandom(90));
      repeat (2) tick();
      rst = 1'b0;
      repeat (5) tick();
      expect_out(3'b000);
      wait_bit(1, 1'b1);
      expect_out(3'b010);
      // Single-cycle trip; alarm latches, relay drops, open-collector lags
      trip = 1'b1;
      tick();
      trip = 1'b0;
      gap = $urandom_range(4, 6);
      repeat (gap) tick();
      expect_out(3'b100);
      wait_bit(0, 1'b1);
      expect_out(3'b101);
      // Clear and trip together: trip wins
      trip = 1'b1;
      clr = 1'b1;
      tick();
      trip = 1'b0;
      clr = 1'b0;
      repeat (4) tick();
      expect_out(3'b101);
      clr = 1'b1;
      tick();
      clr = 1'b0;
      repeat (4) tick();
      expect_out(3'b011);
      wait_bit(0, 1'b0);
      // Normally open sense: coil follows the trip only
      cfg.relay_polarity_select = FAOUT_POL_NO;
      repeat (4) tick();
      expect_out(3'b000);
      trip = 1'b1;
      tick();
      trip = 1'b0;
      wait_bit(0, 1'b1);
      expect_out(3'b111);
      // Other function codes take the alarm off both outputs
      cfg.relay_function_select = 8'($urandom_range(6, 255));
      cfg.oc_function_select = FAOUT_OC_FN_RST;
      repeat (14) tick();
      expect_out(3'b100);
      // Power loss in mid-run: all outputs drop and the hold-off starts again
      cfg = '{FAOUT_RELAY_FN_RST, FAOUT_RELAY_PL_RST, FAOUT_FUNC_ALARM};
      rst = 1'b1;
      tick();
      rst = 1'b0;
      expect_out(3'b000);
      repeat (5) tick();
      expect_out(3'b000);
      wait_bit(1, 1'b1);
      expect_out(3'b010);
      tick();
      end_sim();
   end
endmodule
